/* File: core/wri_top.sv */
// file: reset-class and wake-up entry logic with apb registers
`timescale 1ns/1ps

// What this block does
// - interrupt wake sets cause flag bits
// - enabled interrupt wake loads vector 0008h/0018h
// - enabled interrupt wake saves pc to top-of-stack
// - enabled interrupt wake advances stack pointer
// - unimplemented bits always read zero
// - unchanged bits hold; unknown bits undefined
// - some bits depend on reset condition
// - every reset clears stack pointer to zero
// - push increments pointer, then writes entry
module wri_top
	import wri_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic por_req,
	input wire logic external_reset_pin,
	input wire logic watchdog_timer,
	input wire logic reset_instr,
	input wire logic stack_fault,
	input wire wri_wake_t wake_in,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic [PC_W-1:0] program_counter,
	output logic [SP_W-1:0] return_stack_pointer,
	output logic sleeping,
	output logic [3:0] last_class
);

	// ------------------------------------------------------------
	// input synchronisers (pins from outside the clock domain)
	// ------------------------------------------------------------
	localparam int NSYNC = 6 + INTCTL_W + PFLAG_W;
	logic [NSYNC-1:0] sync1_r;
	logic [NSYNC-1:0] sync2_r;
	logic [NSYNC-1:0] raw_in;
	assign raw_in = {por_req, external_reset_pin, watchdog_timer, reset_instr, stack_fault,
		wake_in.hi_pri, wake_in.int_src, wake_in.per_src};

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_r <= '0;
			sync2_r <= '0;
		end else begin
			sync1_r <= raw_in;
			sync2_r <= sync1_r;
		end
	end

	logic s_por, s_pin, s_wdt, s_rsti, s_stkf, s_hi;
	logic [INTCTL_W-1:0] s_int;
	logic [PFLAG_W-1:0] s_per;
	assign {s_por, s_pin, s_wdt, s_rsti, s_stkf, s_hi, s_int, s_per} = sync2_r;

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	wri_state_t state_r, state_nxt;
	logic [CTRL_W-1:0] ctrl_r, ctrl_nxt;
	logic [INTCTL_W-1:0] intctl_r, intctl_nxt;
	logic [PFLAG_W-1:0] pflag_r, pflag_nxt;
	logic [PC_W-1:0] pc_r, pc_nxt;
	logic [SP_W-1:0] sp_r, sp_nxt;
	logic [3:0] class_r, class_nxt;
	logic [PC_W-1:0] tos_rd;

	// ------------------------------------------------------------
	// event decode
	// ------------------------------------------------------------
	wire warm_rst = s_pin | s_wdt | s_rsti | s_stkf;
	wire int_wake = (|s_int) | (|s_per);
	wire wdt_wake = s_wdt;
	wire gie_any = ctrl_r[CTRL_GLOBAL_HIGH_IRQ_ENABLE] | ctrl_r[CTRL_GLOBAL_LOW_IRQ_ENABLE];
	wire asleep = (state_r == ST_SLEEP);
	wire do_wake = asleep & !s_por & !warm_rst & int_wake;
	wire do_vect = do_wake & gie_any;
	// high vector when hi_pri and the high enable are set, or whenever the low enable is clear; otherwise low vector
	wire use_high = s_hi & ctrl_r[CTRL_GLOBAL_HIGH_IRQ_ENABLE] | !ctrl_r[CTRL_GLOBAL_LOW_IRQ_ENABLE];
	wire [PC_W-1:0] vect = use_high ? HIGH_VECTOR : LOW_VECTOR;
	// saturate so a full stack never wraps onto the reset marker slot
	wire [SP_W-1:0] sp_inc = (sp_r == SP_MAX) ? SP_MAX : sp_r + SP_ONE;
	wire push_we = (state_r == ST_VECT);

	// ------------------------------------------------------------
	// apb decode
	// ------------------------------------------------------------
	wire acc = psel & penable;
	wire wr = acc & pwrite;
	wire hit_ctrl = (paddr == A_CTRL);
	wire hit_pc = (paddr == A_PC);
	wire hit_sp = (paddr == A_SP);
	wire hit_ic = (paddr == A_INTCTL);
	wire hit_pf = (paddr == A_PFLAG);
	wire mapped = hit_ctrl | hit_pc | hit_sp | hit_ic | hit_pf | (paddr == A_STATUS)
		| (paddr == A_TOS) | (paddr == A_CAUSE);

	function automatic logic [31:0] rd_mux(input logic [ADDR_W-1:0] a);
		logic [31:0] v;
		v = 32'h0000_0000;
		case (a)
			A_CTRL: v = {29'h0, ctrl_r};
			A_STATUS: v = {29'h0, state_r};
			A_PC: v = {11'h0, pc_r};
			A_SP: v = {27'h0, sp_r};
			A_TOS: v = {11'h0, tos_rd};
			A_INTCTL: v = {29'h0, intctl_r};
			A_PFLAG: v = {24'h0, pflag_r};
			A_CAUSE: v = {28'h0, class_r};
			default: v = 32'h0000_0000;
		endcase
		return v;
	endfunction

	// ------------------------------------------------------------
	// next-state logic
	// ------------------------------------------------------------
	always_comb begin
		state_nxt = state_r;
		ctrl_nxt = ctrl_r;
		intctl_nxt = intctl_r;
		pflag_nxt = pflag_r;
		pc_nxt = pc_r;
		sp_nxt = sp_r;
		class_nxt = CL_NONE;
		// software writes first so hardware events below win over them
		if (wr && hit_ctrl) ctrl_nxt = pwdata[CTRL_W-1:0];
		if (wr && hit_pc) pc_nxt = pwdata[PC_W-1:0];
		if (wr && hit_sp) sp_nxt = pwdata[SP_W-1:0];
		if (wr && hit_ic) intctl_nxt = intctl_r & ~pwdata[INTCTL_W-1:0];
		if (wr && hit_pf) pflag_nxt = pflag_r & ~pwdata[PFLAG_W-1:0];
		if (wr && hit_ctrl && pwdata[CTRL_SLEEP]) state_nxt = ST_SLEEP;
		// flags are sticky whenever a source fires
		intctl_nxt = intctl_nxt | s_int;
		pflag_nxt = pflag_nxt | s_per;
		case (state_r)
			ST_RUN: begin
			end
			ST_SLEEP: begin
				if (do_vect) begin
					pc_nxt = vect;
					sp_nxt = sp_inc;
					state_nxt = ST_VECT;
					class_nxt = CL_WAKE;
				end else if (do_wake || (wdt_wake && !s_por)) begin
					state_nxt = ST_RUN;
					class_nxt = CL_WAKE;
				end
			end
			ST_VECT: state_nxt = ST_RUN;
			default: state_nxt = ST_RUN;
		endcase
		ctrl_nxt[CTRL_SLEEP] = 1'b0;
		// warm resets: pc, sp, ctrl return; flag bits keep their value
		if (warm_rst && !(asleep && wdt_wake && !s_pin && !s_rsti && !s_stkf)) begin
			pc_nxt = RESET_VECTOR;
			sp_nxt = SP_RESET;
			ctrl_nxt = CTRL_POR;
			state_nxt = ST_RUN;
			class_nxt = CL_WARM;
		end
		// power-on and brown-out: everything to its cold value
		if (s_por) begin
			pc_nxt = RESET_VECTOR;
			sp_nxt = SP_RESET;
			ctrl_nxt = CTRL_POR;
			intctl_nxt = INTCTL_RESET;
			pflag_nxt = PFLAG_RESET;
			state_nxt = ST_RUN;
			class_nxt = CL_POR;
		end
	end

	// push writes the saved pc one cycle after the pointer moved
	logic [PC_W-1:0] saved_pc_r;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			saved_pc_r <= RESET_VECTOR;
		end else if (do_vect && state_r == ST_SLEEP) begin
			saved_pc_r <= pc_r;
		end
	end

	wri_stack_mem u_stack (
		.pclk(pclk),
		.we(push_we),
		.waddr(sp_r),
		.wdata(saved_pc_r),
		.raddr(sp_nxt),
		.rdata(tos_rd)
	);

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r <= ST_RUN;
			ctrl_r <= CTRL_POR;
			intctl_r <= INTCTL_RESET;
			pflag_r <= PFLAG_RESET;
			pc_r <= RESET_VECTOR;
			sp_r <= SP_RESET;
			class_r <= CL_POR;
		end else begin
			state_r <= state_nxt;
			ctrl_r <= ctrl_nxt;
			intctl_r <= intctl_nxt;
			pflag_r <= pflag_nxt;
			pc_r <= pc_nxt;
			sp_r <= sp_nxt;
			if (class_nxt != CL_NONE) class_r <= class_nxt;
		end
	end

	// registered outputs; apb answers in the access cycle, zero wait
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
			program_counter <= RESET_VECTOR;
			return_stack_pointer <= SP_RESET;
			sleeping <= 1'b0;
			last_class <= CL_POR;
		end else begin
			pready <= psel & !penable;
			pslverr <= psel & !penable & !mapped;
			prdata <= (psel & !penable & !pwrite) ? rd_mux(paddr) : 32'h0000_0000;
			program_counter <= pc_nxt;
			return_stack_pointer <= sp_nxt;
			sleeping <= (state_nxt == ST_SLEEP);
			last_class <= (class_nxt != CL_NONE) ? class_nxt : class_r;
		end
	end

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	sequence s_enabled_wake;
		do_vect && state_r == ST_SLEEP;
	endsequence

	property p_vector_load;
		@(posedge pclk) disable iff (!presetn)
		s_enabled_wake |=> (pc_r == HIGH_VECTOR || pc_r == LOW_VECTOR);
	endproperty
	a_vector_load: assert property (p_vector_load) else $error("no vector load");

	property p_sp_advance;
		@(posedge pclk) disable iff (!presetn)
		(s_enabled_wake and (sp_r != SP_MAX && !warm_rst)) |=> sp_r == $past(sp_r) + SP_ONE;
	endproperty
	a_sp_advance: assert property (p_sp_advance) else $error("sp not advanced");

	property p_push_order;
		@(posedge pclk) disable iff (!presetn)
		s_enabled_wake |=> push_we && saved_pc_r == $past(pc_r);
	endproperty
	a_push_order: assert property (p_push_order) else $error("push out of order");

	property p_flag_set;
		@(posedge pclk) disable iff (!presetn)
		(|s_per && !s_por) |=> (pflag_r & $past(s_per)) == $past(s_per);
	endproperty
	a_flag_set: assert property (p_flag_set) else $error("flag lost");

	property p_sp_reset;
		@(posedge pclk) disable iff (!presetn)
		(s_por || (warm_rst && !asleep)) |=> sp_r == SP_RESET;
	endproperty
	a_sp_reset: assert property (p_sp_reset) else $error("sp not cleared");

	property p_por_class;
		@(posedge pclk) disable iff (!presetn)
		s_por |=> class_r == CL_POR && pflag_r == PFLAG_RESET;
	endproperty
	a_por_class: assert property (p_por_class) else $error("por pattern wrong");

	property p_warm_keeps;
		@(posedge pclk) disable iff (!presetn)
		(warm_rst && !s_por && !asleep && !(|s_per) && !wr) |=> pflag_r == $past(pflag_r);
	endproperty
	a_warm_keeps: assert property (p_warm_keeps) else $error("warm reset lost bits");

	property p_zero_high;
		@(posedge pclk) disable iff (!presetn)
		pready |-> prdata[31:PC_W] == 11'h000;
	endproperty
	a_zero_high: assert property (p_zero_high) else $error("unused bits set");

	// watchdog while asleep is a wake, not a reset: pointer must survive it
	property p_wdt_wake;
		@(posedge pclk) disable iff (!presetn)
		(asleep && s_wdt && !s_pin && !s_rsti && !s_stkf && !s_por && !int_wake && !wr)
			|=> state_r == ST_RUN && sp_r == $past(sp_r);
	endproperty
	a_wdt_wake: assert property (p_wdt_wake) else $error("watchdog wake reset the pointer");

endmodule

/* File: core/wri_pkg.sv */
// package: shared constants and types for the wake-up and reset entry block
package wri_pkg;

	// ------------------------------------------------------------
	// widths
	// ------------------------------------------------------------
	localparam int PC_W = 21;
	localparam int SP_W = 5;
	localparam int ADDR_W = 12;
	localparam int STK_DEPTH = 32;

	// ------------------------------------------------------------
	// vectors and reset values
	// ------------------------------------------------------------
	localparam logic [PC_W-1:0] RESET_VECTOR = 21'h000000;
	localparam logic [PC_W-1:0] HIGH_VECTOR = 21'h000008;
	localparam logic [PC_W-1:0] LOW_VECTOR = 21'h000018;
	localparam logic [SP_W-1:0] SP_RESET = 5'h00;
	localparam logic [SP_W-1:0] SP_ONE = 5'h01;
	localparam logic [SP_W-1:0] SP_MAX = 5'h1f;

	// ------------------------------------------------------------
	// register byte addresses (apb, one word each)
	// ------------------------------------------------------------
	localparam logic [ADDR_W-1:0] A_CTRL = 12'h000;
	localparam logic [ADDR_W-1:0] A_STATUS = 12'h004;
	localparam logic [ADDR_W-1:0] A_PC = 12'h008;
	localparam logic [ADDR_W-1:0] A_SP = 12'h00c;
	localparam logic [ADDR_W-1:0] A_TOS = 12'h010;
	localparam logic [ADDR_W-1:0] A_INTCTL = 12'h014;
	localparam logic [ADDR_W-1:0] A_PFLAG = 12'h018;
	localparam logic [ADDR_W-1:0] A_CAUSE = 12'h01c;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int CTRL_GLOBAL_HIGH_IRQ_ENABLE = 0;
	localparam int CTRL_GLOBAL_LOW_IRQ_ENABLE = 1;
	localparam int CTRL_SLEEP = 2;
	localparam int CTRL_W = 3;
	localparam int INTCTL_W = 3;
	localparam int PFLAG_W = 8;
	// flag registers: interrupt_control_regs bits 2:0, peripheral_flag_regs bits 7:0
	localparam logic [INTCTL_W-1:0] INTCTL_RESET = 3'h0;
	localparam logic [PFLAG_W-1:0] PFLAG_RESET = 8'h00;
	localparam logic [CTRL_W-1:0] CTRL_POR = 3'h0;

	// reset / wake-up class codes, one-hot
	typedef enum logic [3:0] {
		CL_NONE = 4'b0001,
		CL_POR = 4'b0010,
		CL_WARM = 4'b0100,
		CL_WAKE = 4'b1000
	} wri_class_t;

	typedef enum logic [2:0] {
		ST_RUN = 3'b001,
		ST_SLEEP = 3'b010,
		ST_VECT = 3'b100
	} wri_state_t;

	// wake source bundle from the outside world
	typedef struct packed {
		logic wdt;
		logic hi_pri;
		logic [INTCTL_W-1:0] int_src;
		logic [PFLAG_W-1:0] per_src;
	} wri_wake_t;

endpackage

/* File: core/wri_stack_mem.sv */
// file: return-stack storage, registered read port
`timescale 1ns/1ps

module wri_stack_mem
	import wri_pkg::*;
(
	input wire logic pclk,
	input wire logic we,
	input wire logic [SP_W-1:0] waddr,
	input wire logic [PC_W-1:0] wdata,
	input wire logic [SP_W-1:0] raddr,
	output logic [PC_W-1:0] rdata
);

	logic [PC_W-1:0] mem [STK_DEPTH];

	// no reset: contents are undefined after power-up, by design
	always_ff @(posedge pclk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
		rdata <= (raddr == SP_RESET) ? RESET_VECTOR : mem[raddr];
	end

endmodule

/* File: verification/wri_top_tb.sv */
// testbench for the wake-up and reset entry block
`timescale 1ns/1ps

`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin errors++; $display("FAIL %0t got %h exp %h", $time, (g), (e)); end end

module wri_top_tb
	import wri_pkg::*;
();

	// ------------------------------------------------------------
	// stimulus and observation signals
	// ------------------------------------------------------------
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic por_req = 1'b0;
	logic [3:0] warm = 4'h0; // stack fault, instr, watchdog, pin
	wri_wake_t wake_in = '0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [ADDR_W-1:0] paddr = '0;
	logic [31:0] pwdata = '0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [PC_W-1:0] program_counter;
	logic [SP_W-1:0] return_stack_pointer;
	logic sleeping;
	logic [3:0] last_class;
	int errors = 0;
	int cmp_count = 0;
	logic [31:0] rd;
	logic er;
	logic [PC_W-1:0] wpc;
	logic [SP_W-1:0] wsp;

	always #2.5 pclk = ~pclk;

	wri_top u_dut (
		.pclk(pclk),
		.presetn(presetn),
		.por_req(por_req),
		.external_reset_pin(warm[0]),
		.watchdog_timer(warm[1]),
		.reset_instr(warm[2]),
		.stack_fault(warm[3]),
		.wake_in(wake_in),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.program_counter(program_counter),
		.return_stack_pointer(return_stack_pointer),
		.sleeping(sleeping),
		.last_class(last_class)
	);

	// ------------------------------------------------------------
	// bus and helper tasks
	// ------------------------------------------------------------
	// one apb transfer; request held until pready is seen at an edge
	task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 20) begin
			errors++;
			$display("FAIL %0t bus never answered", $time);
		end
	endtask

	task automatic rchk(input logic [ADDR_W-1:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		`CHK(rd, e)
	endtask

	// enter sleep, raise sources, capture pc and sp at the wake edge
	task automatic sleep_wake(input logic [2:0] ctrl, input wri_wake_t src);
		int n;
		apb(1'b1, A_CTRL, {29'h0, ctrl});
		@(posedge pclk);
		#1;
		`CHK(sleeping, 1'b1)
		@(posedge pclk);
		wake_in <= src;
		for (n = 0; n < 20 && sleeping !== 1'b0; n++) begin
			@(posedge pclk);
			#1;
		end
		`CHK(sleeping, 1'b0)
		wpc = program_counter;
		wsp = return_stack_pointer;
		@(posedge pclk);
		wake_in <= '0;
		// let the source synchroniser drain before touching flags
		repeat (4) @(posedge pclk);
	endtask

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_reset;
		rchk(A_SP, 32'h0);
		rchk(A_CAUSE, 32'h2);
		rchk(A_CTRL, 32'h0);
		rchk(A_STATUS, 32'h1);
		apb(1'b0, 12'h020, 32'h0);
		`CHK(er, 1'b1)
		`CHK(rd, 32'h0)
		apb(1'b1, A_SP, 32'hffff_ffe5);
		rchk(A_SP, 32'h5);
		apb(1'b1, A_SP, 32'h0);
	endtask

	task automatic t_hi;
		apb(1'b1, A_PC, 32'h1234);
		sleep_wake(3'b101, wri_wake_t'{1'b0, 1'b1, 3'h1, 8'h00});
		`CHK(wpc, HIGH_VECTOR)
		`CHK(wsp, SP_ONE)
		rchk(A_TOS, 32'h1234);
		rchk(A_INTCTL, 32'h1);
		rchk(A_CAUSE, 32'h8);
	endtask

	// second push lands one entry higher, low vector taken
	task automatic t_lo;
		apb(1'b1, A_PC, 32'h2468);
		sleep_wake(3'b111, wri_wake_t'{1'b0, 1'b0, 3'h0, 8'h40});
		`CHK(wpc, LOW_VECTOR)
		`CHK(wsp, 5'h02)
		rchk(A_TOS, 32'h2468);
		rchk(A_PFLAG, 32'h40);
	endtask

	// globals off: flags still record the cause, no vectoring
	task automatic t_off;
		apb(1'b1, A_PC, 32'h0abc);
		sleep_wake(3'b100, wri_wake_t'{1'b0, 1'b0, 3'h0, 8'h08});
		`CHK(wpc, 21'h000abc)
		`CHK(wsp, 5'h02)
		rchk(A_PFLAG, 32'h48);
		apb(1'b1, A_PFLAG, 32'h48);
		rchk(A_PFLAG, 32'h0);
	endtask

	// watchdog pulse while asleep wakes only: pointer kept, class says wake
	task automatic t_wdog;
		apb(1'b1, A_SP, 32'h3);
		apb(1'b1, A_CTRL, 32'h4);
		@(posedge pclk);
		warm <= 4'h2;
		// one cycle only, a longer level would look like a watchdog reset once awake
		@(posedge pclk);
		warm <= 4'h0;
		repeat (6) @(posedge pclk);
		`CHK(sleeping, 1'b0)
		`CHK(return_stack_pointer, 5'h03)
		`CHK(last_class, 4'h8)
	endtask

	// every warm source: pointer cleared, flags kept
	task automatic t_warm;
		for (int i = 0; i < 4; i++) begin
			apb(1'b1, A_SP, 32'h7);
			@(posedge pclk);
			warm <= 4'h1 << i;
			repeat (4) @(posedge pclk);
			warm <= 4'h0;
			repeat (6) @(posedge pclk);
			`CHK(return_stack_pointer, SP_RESET)
			`CHK(last_class, 4'h4)
			rchk(A_INTCTL, 32'h1);
		end
	endtask

	task automatic t_por;
		apb(1'b1, A_SP, 32'h3);
		@(posedge pclk);
		por_req <= 1'b1;
		repeat (4) @(posedge pclk);
		por_req <= 1'b0;
		repeat (6) @(posedge pclk);
		`CHK(last_class, 4'h2)
		`CHK(return_stack_pointer, SP_RESET)
		rchk(A_INTCTL, 32'h0);
	endtask

	// ------------------------------------------------------------
	// verdict, watchdog and main sequence
	// ------------------------------------------------------------
	task automatic close_out;
		$display("errors=%0d comparisons=%0d", errors, cmp_count);
		if (errors == 0 && cmp_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// generous: the sequence needs well under a thousand cycles
	initial begin
		#50000;
		errors++;
		$display("FAIL %0t watchdog expired", $time);
		close_out();
	end

	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_hi();
		t_lo();
		t_off();
		t_wdog();
		t_warm();
		t_por();
		close_out();
	end

endmodule
